// ==== hdl/tap_cfg.svh ====
// constants for the tilt alarm and periodic output block
`ifndef TAP_CFG_SVH
`define TAP_CFG_SVH
`define TAP_CLK_HZ        40000000
// apb offsets
`define TAP_OFF_CMD       12'h000
`define TAP_OFF_STAT      12'h004
`define TAP_OFF_XPOS      12'h008
`define TAP_OFF_XNEG      12'h00C
`define TAP_OFF_YPOS      12'h010
`define TAP_OFF_YNEG      12'h014
`define TAP_OFF_HYST      12'h018
`define TAP_OFF_SAMPLE    12'h01C
`define TAP_OFF_AVG       12'h020
`define TAP_OFF_RESP      12'h024
// command codes, written to the command register low byte
`define TAP_CMD_PERIODIC  8'h01
`define TAP_CMD_STOP      8'h02
`define TAP_CMD_AL_EN     8'h03
`define TAP_CMD_AL_DIS    8'h04
`define TAP_CMD_FORCE_ON  8'h05
`define TAP_CMD_FORCE_OFF 8'h06
`define TAP_CMD_LIMITS    8'h07
`define TAP_CMD_DEADBAND  8'h08
`define TAP_CMD_LIST      8'h09
`define TAP_CMD_LIST2     8'h0A
// command register fields
`define TAP_CMD_RATE_LSB  8
`define TAP_CMD_AVG_BIT   11
`define TAP_CMD_GLOBAL    12
`define TAP_CMD_BAD_BIT   13
// response codes
`define TAP_RSP_NONE      4'h0
`define TAP_RSP_ECHO      4'h1
`define TAP_RSP_LIM_ERR   4'h2
`define TAP_RSP_HYS_ERR   4'h3
`define TAP_RSP_LIST      4'h4
`define TAP_RSP_LIST2     4'h5
// reset values, units of 1/1000 degree
`define TAP_RST_POS       32'h000003E8
`define TAP_RST_NEG       32'hFFFFFC18
`define TAP_RST_HYST      32'h00000000
// reading periods in ms per rate code
`define TAP_MS_R0         100
`define TAP_MS_R1         250
`define TAP_MS_R2         1000
`define TAP_MS_R3         10000
`define TAP_MS_R4         60000
`define TAP_MS_R5         3600000
`define TAP_MS_R6         43200000
`define TAP_MS_R7         86400000
`define TAP_AVG_N0        10
`define TAP_AVG_N12       4
`endif

// ==== hdl/tap_pkg.sv ====
// types for the tilt alarm and periodic output block
package tap_pkg;
    typedef struct packed {
        logic [31:0] xpos;
        logic [31:0] xneg;
        logic [31:0] ypos;
        logic [31:0] yneg;
        logic [31:0] hyst;
    } tap_limits_t;
    typedef struct packed {
        logic        valid;
        logic [31:0] x;
        logic [31:0] y;
    } tap_sample_t;
    typedef enum logic [1:0] {TAP_ST_OFF, TAP_ST_FILL, TAP_ST_RUN} tap_run_t;
endpackage

// ==== hdl/tap_alarm.sv ====
// alarm comparator with hysteresis on both axes
`timescale 1ns/100ps
`default_nettype none
module tap_alarm
    import tap_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire tap_limits_t lim,
    input  wire tap_sample_t smp,
    input  wire logic        enable,
    output logic             trip
);
    typedef struct packed {
        logic trip;
    } tap_alarm_st_t;
    tap_alarm_st_t s_q;
    tap_alarm_st_t s_d;
    logic over;
    logic hold;
    always_comb begin
        over = ($signed(smp.x) > $signed(lim.xpos)) || ($signed(smp.x) < $signed(lim.xneg))
            || ($signed(smp.y) > $signed(lim.ypos)) || ($signed(smp.y) < $signed(lim.yneg));
        hold = ($signed(smp.x) >= $signed(lim.xpos - lim.hyst))
            || ($signed(smp.x) <= $signed(lim.xneg + lim.hyst))
            || ($signed(smp.y) >= $signed(lim.ypos - lim.hyst))
            || ($signed(smp.y) <= $signed(lim.yneg + lim.hyst));
        s_d = s_q;
        if (!enable) begin
            s_d.trip = 1'b0;
        end else if (smp.valid) begin
            s_d.trip = over || (s_q.trip && hold);
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign trip = s_q.trip;
    // a_trip_on_over
    a_trip_on_over: assert property (@(posedge pclk) disable iff (!presetn)
        enable && smp.valid && over |=> trip) else $error("alarm missed over-threshold");
endmodule
`default_nettype wire

// ==== hdl/tap_avg.sv ====
// sliding window averager over the last n readings
`timescale 1ns/100ps
`default_nettype none
module tap_avg
    import tap_pkg::*;
#(
    parameter int DEPTH = 10
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clear,
    input  wire logic [3:0]  n,
    input  wire tap_sample_t smp,
    output tap_sample_t      avg,
    output logic             full
);
    typedef struct packed {
        logic [DEPTH-1:0][31:0] xw;
        logic [DEPTH-1:0][31:0] yw;
        logic [3:0]             cnt;
        tap_sample_t            out;
    } tap_avg_st_t;
    tap_avg_st_t s_q;
    tap_avg_st_t s_d;
    logic signed [35:0] sx;
    logic signed [35:0] sy;
    always_comb begin
        s_d = s_q;
        s_d.out.valid = 1'b0;
        sx = '0;
        sy = '0;
        if (clear) begin
            s_d.cnt = '0;
        end else if (smp.valid) begin
            s_d.xw = {s_q.xw[DEPTH-2:0], smp.x};
            s_d.yw = {s_q.yw[DEPTH-2:0], smp.y};
            for (int i = 0; i < DEPTH; i++) begin
                if (4'(i) < n) begin
                    sx = sx + 36'($signed(s_d.xw[i]));
                    sy = sy + 36'($signed(s_d.yw[i]));
                end
            end
            if (s_q.cnt < n) begin
                s_d.cnt = s_q.cnt + 4'h1;
            end
            if (s_d.cnt == n) begin
                s_d.out.valid = 1'b1;
                s_d.out.x = 32'(sx / $signed({32'h0, n}));
                s_d.out.y = 32'(sy / $signed({32'h0, n}));
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign avg  = s_q.out;
    assign full = (s_q.cnt == n);
endmodule
`default_nettype wire

// ==== hdl/tap_top.sv ====
// command interpreter: periodic output, averaging, alarm pin, listings
`timescale 1ns/100ps
`default_nettype none
`include "tap_cfg.svh"
module tap_top
    import tap_pkg::*;
#(
    parameter int CLK_HZ = `TAP_CLK_HZ
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        nv_valid,
    input  wire logic        nv_run,
    input  wire logic [3:0]  nv_rate,
    input  wire logic        nv_alarm_en,
    input  wire logic [31:0] sample_x,
    input  wire logic [31:0] sample_y,
    output logic             nv_store,
    output logic             out_valid,
    output logic [31:0]      out_x,
    output logic [31:0]      out_y,
    output logic             alarm_pin
);
    localparam int CPM = CLK_HZ / 1000;
    typedef struct packed {
        tap_run_t    run;
        logic [3:0]  rate;
        logic        alarm_en;
        logic        force_hi;
        tap_limits_t lim;
        logic [31:0] sx;
        logic [31:0] sy;
        logic [63:0] tick;
        logic        take;
        logic        restart;
        logic [3:0]  resp;
        logic        global_cmd;
        logic        nv_store;
        logic        nv_seen;
        logic        out_valid;
        logic [31:0] out_x;
        logic [31:0] out_y;
        logic        pin;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } tap_st_t;
    tap_st_t     s_q;
    tap_st_t     s_d;
    tap_sample_t raw;
    tap_sample_t avg;
    logic        trip;
    logic        avg_full;
    logic [3:0]  avg_n;
    logic        wr;
    logic        rd;
    logic [7:0]  op;
    logic [63:0] period;
    // ----------------------------------------------------------------
    // reading period
    // ----------------------------------------------------------------
    always_comb begin
        unique case (s_q.rate[2:0])
            3'd0: period = 64'(`TAP_MS_R0) * 64'(CPM);
            3'd1: period = 64'(`TAP_MS_R1) * 64'(CPM);
            3'd2: period = 64'(`TAP_MS_R2) * 64'(CPM);
            3'd3: period = 64'(`TAP_MS_R3) * 64'(CPM);
            3'd4: period = 64'(`TAP_MS_R4) * 64'(CPM);
            3'd5: period = 64'(`TAP_MS_R5) * 64'(CPM);
            3'd6: period = 64'(`TAP_MS_R6) * 64'(CPM);
            3'd7: period = 64'(`TAP_MS_R7) * 64'(CPM);
        endcase
        // ten for code 0, four else
        avg_n = (s_q.rate[2:0] == 3'd0) ? 4'(`TAP_AVG_N0) : 4'(`TAP_AVG_N12);
    end
    assign raw.valid = s_q.take;
    assign raw.x     = s_q.sx;
    assign raw.y     = s_q.sy;
    tap_avg #(
        .DEPTH (`TAP_AVG_N0)
    ) u_avg (
        .pclk    (pclk),
        .presetn (presetn),
        .clear   (s_q.run == TAP_ST_OFF || s_q.restart),
        .n       (avg_n),
        .smp     (raw),
        .avg     (avg),
        .full    (avg_full)
    );
    tap_alarm u_alarm (
        .pclk    (pclk),
        .presetn (presetn),
        .lim     (s_q.lim),
        .smp     (raw),
        .enable  (s_q.alarm_en),
        .trip    (trip)
    );
    // ----------------------------------------------------------------
    // apb decode and command interpreter
    // ----------------------------------------------------------------
    assign wr = psel && penable && pwrite && !s_q.pready;
    assign rd = psel && penable && !pwrite && !s_q.pready;
    assign op = pwdata[7:0];
    always_comb begin
        s_d = s_q;
        s_d.pready    = 1'b0;
        s_d.pslverr   = 1'b0;
        s_d.take      = 1'b0;
        s_d.restart   = 1'b0;
        s_d.nv_store  = 1'b0;
        s_d.out_valid = 1'b0;
        if (nv_valid && !s_q.nv_seen) begin
            s_d.nv_seen  = 1'b1;
            s_d.run      = nv_run ? TAP_ST_FILL : TAP_ST_OFF;
            s_d.rate     = nv_rate;
            s_d.alarm_en = nv_alarm_en;
        end
        if (s_q.run != TAP_ST_OFF) begin
            if (s_q.tick + 64'h1 >= period) begin
                s_d.tick = '0;
                s_d.take = 1'b1;
                s_d.sx   = sample_x;
                s_d.sy   = sample_y;
            end else begin
                s_d.tick = s_q.tick + 64'h1;
            end
        end else begin
            s_d.tick = '0;
        end
        if (s_q.run == TAP_ST_FILL && avg_full) begin
            s_d.run = TAP_ST_RUN;
        end
        if (s_q.rate[3]) begin
            s_d.out_valid = avg.valid;
            if (avg.valid) begin
                s_d.out_x = avg.x;
                s_d.out_y = avg.y;
            end
        end else if (s_q.take && s_q.run != TAP_ST_OFF) begin
            s_d.out_valid = 1'b1;
            s_d.out_x     = s_q.sx;
            s_d.out_y     = s_q.sy;
        end
        if (wr || rd) begin
            s_d.pready = 1'b1;
        end
        if (wr) begin
            unique case (paddr)
                `TAP_OFF_CMD: begin
                    s_d.resp       = `TAP_RSP_NONE;
                    // global command flag kept for echo
                    s_d.global_cmd = pwdata[`TAP_CMD_GLOBAL];
                    unique case (op)
                        `TAP_CMD_PERIODIC: begin
                            s_d.rate     = pwdata[`TAP_CMD_AVG_BIT:`TAP_CMD_RATE_LSB];
                            s_d.run      = TAP_ST_FILL;
                            s_d.restart  = 1'b1;
                            s_d.nv_store = 1'b1;
                        end
                        `TAP_CMD_STOP: begin
                            s_d.run      = TAP_ST_OFF;
                            s_d.nv_store = 1'b1;
                            s_d.resp     = `TAP_RSP_ECHO;
                        end
                        `TAP_CMD_AL_EN: begin
                            s_d.alarm_en = 1'b1;
                            s_d.nv_store = 1'b1;
                        end
                        `TAP_CMD_AL_DIS: begin
                            s_d.alarm_en = 1'b0;
                            s_d.nv_store = 1'b1;
                        end
                        `TAP_CMD_FORCE_ON: s_d.force_hi = 1'b1;
                        `TAP_CMD_FORCE_OFF: s_d.force_hi = 1'b0;
                        `TAP_CMD_LIMITS: begin
                            if (pwdata[`TAP_CMD_BAD_BIT]) begin
                                s_d.resp = `TAP_RSP_LIM_ERR;
                            end else begin
                                s_d.nv_store = 1'b1;
                            end
                        end
                        `TAP_CMD_DEADBAND: begin
                            if (pwdata[`TAP_CMD_BAD_BIT]) begin
                                s_d.resp = `TAP_RSP_HYS_ERR;
                            end else begin
                                s_d.nv_store = 1'b1;
                            end
                        end
                        `TAP_CMD_LIST: s_d.resp = `TAP_RSP_LIST;
                        `TAP_CMD_LIST2: s_d.resp = `TAP_RSP_LIST2;
                        default: s_d.pslverr = 1'b1;
                    endcase
                end
                `TAP_OFF_XPOS: s_d.lim.xpos = pwdata;
                `TAP_OFF_XNEG: s_d.lim.xneg = pwdata;
                `TAP_OFF_YPOS: s_d.lim.ypos = pwdata;
                `TAP_OFF_YNEG: s_d.lim.yneg = pwdata;
                `TAP_OFF_HYST: s_d.lim.hyst = pwdata;
                default: s_d.pslverr = 1'b1;
            endcase
        end
        if (rd) begin
            unique case (paddr)
                `TAP_OFF_STAT:   s_d.prdata = {20'h0, s_q.global_cmd, s_q.force_hi,
                                               s_q.alarm_en, s_q.pin, s_q.rate,
                                               s_q.run != TAP_ST_OFF,
                                               s_q.run == TAP_ST_RUN, 2'h0};
                `TAP_OFF_XPOS:   s_d.prdata = s_q.lim.xpos;
                `TAP_OFF_XNEG:   s_d.prdata = s_q.lim.xneg;
                `TAP_OFF_YPOS:   s_d.prdata = s_q.lim.ypos;
                `TAP_OFF_YNEG:   s_d.prdata = s_q.lim.yneg;
                `TAP_OFF_HYST:   s_d.prdata = s_q.lim.hyst;
                `TAP_OFF_SAMPLE: s_d.prdata = s_q.sx;
                `TAP_OFF_AVG:    s_d.prdata = s_q.out_x;
                `TAP_OFF_RESP:   s_d.prdata = {28'h0, s_q.resp};
                `TAP_OFF_CMD:    s_d.prdata = 32'h00000000;
                default: begin
                    s_d.prdata  = 32'h00000000;
                    s_d.pslverr = 1'b1;
                end
            endcase
        end
        s_d.pin = s_q.force_hi || (s_q.alarm_en && trip);
    end
    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q           <= '0;
            // off by default; enable on; force off
            s_q.run       <= TAP_ST_OFF;
            s_q.alarm_en  <= 1'b1;
            s_q.force_hi  <= 1'b0;
            s_q.lim.xpos  <= `TAP_RST_POS;
            s_q.lim.xneg  <= `TAP_RST_NEG;
            s_q.lim.ypos  <= `TAP_RST_POS;
            s_q.lim.yneg  <= `TAP_RST_NEG;
            s_q.lim.hyst  <= `TAP_RST_HYST;
        end else begin
            s_q <= s_d;
        end
    end
    assign prdata    = s_q.prdata;
    assign pready    = s_q.pready;
    assign pslverr   = s_q.pslverr;
    assign nv_store  = s_q.nv_store;
    assign out_valid = s_q.out_valid;
    assign out_x     = s_q.out_x;
    assign out_y     = s_q.out_y;
    assign alarm_pin = s_q.pin;
    // a_force_pin
    a_force_pin: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.force_hi |=> alarm_pin) else $error("forced pin not high");
    // a_disabled_low
    a_disabled_low: assert property (@(posedge pclk) disable iff (!presetn)
        !s_q.force_hi && !s_q.alarm_en |=> !alarm_pin) else $error("disabled pin high");
    // a_stop_echo
    a_stop_echo: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == `TAP_OFF_CMD && op == `TAP_CMD_STOP
        |=> s_q.resp == `TAP_RSP_ECHO && nv_store && s_q.run == TAP_ST_OFF)
        else $error("stop not echoed");
    // a_avg_wait
    a_avg_wait: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.rate[3] && s_q.run == TAP_ST_FILL && !avg.valid |=> !out_valid)
        else $error("early averaged output");
    // a_apb_ready
    a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready) else $error("apb no ready");
    // a_lim_err
    a_lim_err: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == `TAP_OFF_CMD && op == `TAP_CMD_LIMITS && pwdata[`TAP_CMD_BAD_BIT]
        |=> s_q.resp == `TAP_RSP_LIM_ERR) else $error("limit error missing");
    // a_hys_err
    a_hys_err: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == `TAP_OFF_CMD && op == `TAP_CMD_DEADBAND && pwdata[`TAP_CMD_BAD_BIT]
        |=> s_q.resp == `TAP_RSP_HYS_ERR) else $error("deadband error missing");
    // a_release_low
    a_release_low: assert property (@(posedge pclk) disable iff (!presetn)
        !s_q.alarm_en && $fell(s_q.force_hi) |=> !alarm_pin) else $error("release kept high");
    // ----------------------------------------------------------------
    // stream, window and alarm checks
    // ----------------------------------------------------------------
    // raw reading streamed
    a_raw_stream: assert property (@(posedge pclk) disable iff (!presetn)
        !s_q.rate[3] && s_q.take && s_q.run != TAP_ST_OFF |=> out_valid)
        else $error("raw reading not streamed");
    a_restart_empty: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.restart |=> !avg_full)
        else $error("window not emptied");
    a_trip_pin: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.alarm_en && !s_q.force_hi && trip |=> alarm_pin)
        else $error("trip not on pin");
endmodule
`default_nettype wire

// ==== bench/tap_far_model.sv ====
// sensor and nonvolatile image model at the far side of the block
`timescale 1ns/100ps
`default_nettype none
module tap_far_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [31:0] set_x,
    input  wire logic [31:0] set_y,
    input  wire logic        nv_store,
    output logic [31:0]      sample_x,
    output logic [31:0]      sample_y,
    output logic             nv_valid,
    output logic             nv_run,
    output logic [3:0]       nv_rate,
    output logic             nv_alarm_en,
    output logic [7:0]       store_cnt
);
    assign nv_run      = 1'b0;
    assign nv_rate     = 4'h0;
    assign nv_alarm_en = 1'b1;
    assign sample_x    = set_x;
    assign sample_y    = set_y;
    // image ready one cycle after reset, stores counted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nv_valid  <= 1'b0;
            store_cnt <= 8'h00;
        end else begin
            nv_valid  <= 1'b1;
            if (nv_store) begin
                store_cnt <= store_cnt + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ==== bench/tilt_alarm_and_periodic_output_tb_top.sv ====
// self-checking bench for the tilt alarm and periodic output block
`timescale 1ns/100ps
`default_nettype none
`include "tap_cfg.svh"
module tilt_alarm_and_periodic_output_tb_top;
    typedef struct {
        logic        wr;
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] e;
        int          per;
    } tap_tb_row_t;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        pready, pslverr, nv_valid, nv_run, nv_alarm_en, nv_store, out_valid;
    logic        alarm_pin, er;
    logic [3:0]  nv_rate;
    logic [7:0]  store_cnt;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, set_x = 32'h00000123, set_y = 32'h0;
    logic [31:0] prdata, sample_x, sample_y, out_x, out_y, rd;
    int          err_count = 0, num_checks = 0, c;
    tap_tb_row_t rows[15];

    tap_top #(.CLK_HZ(1000)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .nv_valid(nv_valid), .nv_run(nv_run), .nv_rate(nv_rate), .nv_alarm_en(nv_alarm_en),
        .sample_x(sample_x), .sample_y(sample_y), .nv_store(nv_store),
        .out_valid(out_valid), .out_x(out_x), .out_y(out_y), .alarm_pin(alarm_pin));
    tap_far_model far (
        .pclk(pclk), .presetn(presetn), .set_x(set_x), .set_y(set_y), .nv_store(nv_store),
        .sample_x(sample_x), .sample_y(sample_y), .nv_valid(nv_valid), .nv_run(nv_run),
        .nv_rate(nv_rate), .nv_alarm_en(nv_alarm_en), .store_cnt(store_cnt));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi, input string msg);
        num_checks++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("mismatch %0t: %s got %0d cycles", $time, msg, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rdat, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        chk_rng(n, 0, 19, "apb answer");
        rdat = prdata;
        err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_valid(input int lim, output int cnt);
        cnt = 0;
        do begin
            @(posedge pclk);
            cnt++;
        end while (out_valid !== 1'b1 && cnt < lim);
    endtask
    task automatic step(input logic [31:0] cmd, input logic [31:0] x, input logic [31:0] y,
                        input logic e);
        if (cmd !== 32'h0) begin
            apb(1'b1, `TAP_OFF_CMD, cmd, rd, er);
        end
        set_x <= x;
        set_y <= y;
        repeat (105) @(posedge pclk);
        chk32({31'h0, alarm_pin}, {31'h0, e}, "alarm pin");
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        repeat (50000) @(posedge pclk);
        err_count++;
        $display("mismatch %0t: watchdog expired", $time);
        report_and_stop();
    end
    initial begin
        rows = '{
            '{1'b0, `TAP_OFF_XPOS, 32'h0, `TAP_RST_POS, 0},
            '{1'b0, `TAP_OFF_XNEG, 32'h0, `TAP_RST_NEG, 0},
            '{1'b0, `TAP_OFF_YPOS, 32'h0, `TAP_RST_POS, 0},
            '{1'b0, `TAP_OFF_YNEG, 32'h0, `TAP_RST_NEG, 0},
            '{1'b0, `TAP_OFF_HYST, 32'h0, `TAP_RST_HYST, 0},
            '{1'b1, `TAP_OFF_CMD, 32'h00002007, 32'h2, 0},
            '{1'b1, `TAP_OFF_CMD, 32'h00002008, 32'h3, 0},
            '{1'b1, `TAP_OFF_CMD, 32'h00000009, 32'h4, 0},
            '{1'b1, `TAP_OFF_CMD, 32'h0000000A, 32'h5, 0},
            '{1'b1, `TAP_OFF_CMD, 32'h00000001, 32'h0, 100},
            '{1'b1, `TAP_OFF_CMD, 32'h00000101, 32'h0, 250},
            '{1'b1, `TAP_OFF_CMD, 32'h00000201, 32'h0, 1000},
            '{1'b1, `TAP_OFF_CMD, 32'h00000301, 32'h0, 10000},
            '{1'b1, `TAP_OFF_CMD, 32'h00000002, 32'h1, 0},
            '{1'b1, `TAP_OFF_CMD, 32'h00001002, 32'h1, 0}};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        chk32({31'h0, alarm_pin}, 32'h0, "pin after reset");
        apb(1'b0, `TAP_OFF_STAT, 32'h0, rd, er);
        chk32(rd & 32'h0000060C, 32'h00000200, "status defaults");
        apb(1'b0, 12'h0FC, 32'h0, rd, er);
        chk32({31'h0, er}, 32'h1, "unmapped error");
        chk32(rd, 32'h0, "unmapped data");
        $display("test reset and refusal done");
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].a, rows[i].d, rd, er);
            if (rows[i].per > 0) begin
                repeat (2) wait_valid(rows[i].per + 100, c);
                chk_rng(c, rows[i].per, rows[i].per, "output period");
                chk32(out_x, set_x, "raw x");
                chk32(out_y, set_y, "raw y");
            end else if (rows[i].wr) begin
                apb(1'b0, `TAP_OFF_RESP, 32'h0, rd, er);
                chk32(rd, rows[i].e, "response code");
            end else begin
                chk32(rd, rows[i].e, "reset value");
            end
        end
        wait_valid(1100, c);
        chk_rng(c, 1100, 1100, "output after stop");
        chk32({24'h0, store_cnt}, 32'h6, "store pulses");
        $display("test table done");
        apb(1'b1, `TAP_OFF_HYST, 32'h000000C8, rd, er);
        step(32'h00000001, 32'h000003E9, 32'h0, 1'b1);
        step(32'h0, 32'h00000384, 32'h0, 1'b1);
        step(32'h0, 32'h0000031F, 32'h0, 1'b0);
        step(32'h0, 32'h0, 32'hFFFFFC17, 1'b1);
        step(32'h0, 32'h0, 32'hFFFFFCDF, 1'b1);
        step(32'h0, 32'h0, 32'hFFFFFCE1, 1'b0);
        step(32'h0, 32'h0, 32'hFFFFFC17, 1'b1);
        step(32'h00000004, 32'h0, 32'hFFFFFC17, 1'b0);
        step(32'h00000005, 32'h0, 32'hFFFFFC17, 1'b1);
        step(32'h00000003, 32'h0, 32'hFFFFFC17, 1'b1);
        step(32'h00000004, 32'h0, 32'hFFFFFC17, 1'b1);
        step(32'h00000006, 32'h0, 32'hFFFFFC17, 1'b0);
        step(32'h00000003, 32'h0, 32'hFFFFFC17, 1'b1);
        step(32'h00000005, 32'h0, 32'h0, 1'b1);
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk32({31'h0, alarm_pin}, 32'h0, "force after reset");
        $display("test alarm done");
        set_x <= 32'h000007D0;
        apb(1'b1, `TAP_OFF_CMD, 32'h00000901, rd, er);
        wait_valid(1100, c);
        chk_rng(c, 750, 1004, "first average delay");
        chk32(out_x, 32'h000007D0, "full window");
        set_x <= 32'h00001770;
        wait_valid(1100, c);
        chk_rng(c, 250, 250, "average rate");
        chk32(out_x, 32'h00000BB8, "slide one");
        wait_valid(1100, c);
        chk32(out_x, 32'h00000FA0, "slide two");
        apb(1'b1, `TAP_OFF_CMD, 32'h00000801, rd, er);
        wait_valid(1100, c);
        chk_rng(c, 900, 1004, "ten reading delay");
        chk32(out_x, 32'h00001770, "ten reading average");
        $display("test averaging done");
        report_and_stop();
    end
endmodule
`default_nettype wire
